// ---- core/dmaseq_top.v ----
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "dmaseq_consts.vh"

module dmaseq_top #(
    parameter CW = 16,
    parameter AW = 16,
    parameter RIPPLE_CYC = `DMASEQ_RIPPLE_CYC
) (
    // clock and bus reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // power control
    input wire power_up_memory_disable_n,
    input wire power_fail_detect_n,
    // peripheral side
    input wire xfer_req,
    input wire xfer_error,
    output reg xfer_grant,
    // shared bus
    input wire halt_ack_n,
    input wire memory_ack_n,
    output reg halt_req_n,
    output reg mem_start_n,
    output reg mem_write,
    output reg mem_byte,
    output reg [AW-1:0] mem_addr,
    // priority chain
    input wire dma_priority_in_n,
    output reg dma_priority_out_n,
    // end of operation
    output reg end_of_operation_interrupt
);

    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_ACQ = 6'h02;
    localparam [5:0] S_AUCT = 6'h04;
    localparam [5:0] S_XFER = 6'h08;
    localparam [5:0] S_POST = 6'h10;
    localparam [5:0] S_TERM = 6'h20;
    localparam [31:0] RIPPLE_LAST_W = RIPPLE_CYC - 1;
    localparam [2:0] TMR_LAST = RIPPLE_LAST_W[2:0];

    // mode register, bus reset domain
    reg [3:0] ctrl_r;
    // sequencer, power-up domain
    reg [5:0] st_r;
    reg rq_r;
    reg sync_r;
    reg win_r;
    reg [2:0] tmr_r;
    reg [CW-1:0] count_r;
    reg [AW-1:0] addr_r;
    reg active_r;
    reg fl_done_r;
    reg fl_err_r;
    reg fl_pf_r;
    reg halt_ack_n_q;
    reg memory_ack_n_q;

    wire setup = psel & ~penable;
    wire wr_acc = psel & penable & pwrite;
    wire go_p = wr_acc & (paddr == `DMASEQ_CTRL_OFS) & pwdata[`DMASEQ_CTRL_GO] & ~active_r;
    wire cnt_we = wr_acc & (paddr == `DMASEQ_COUNT_OFS) & ~active_r;
    wire adr_we = wr_acc & (paddr == `DMASEQ_ADDR_OFS) & ~active_r;
    wire halt_ack_n_lead = halt_ack_n_q & ~halt_ack_n;
    wire memory_ack_n_trail = ~memory_ack_n_q & memory_ack_n;
    wire pf = ~power_fail_detect_n;
    wire ripple_done = ctrl_r[`DMASEQ_CTRL_SINGLE] | (tmr_r == TMR_LAST);
    wire last_xfer = (count_r == {{(CW-1){1'b0}}, 1'b1});

    function [31:0] status_word;
        input [5:0] st;
        input [6:0] fl;
        begin
            status_word = {16'h0000, 2'b00, st, 1'b0, fl};
        end
    endfunction

    // apb register file
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `DMASEQ_CTRL_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (wr_acc && paddr == `DMASEQ_CTRL_OFS && !active_r) begin
                ctrl_r <= {pwdata[3:1], 1'b0};
            end
            if (setup) begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
                if (paddr == `DMASEQ_CTRL_OFS) begin
                    prdata <= {28'h000_0000, ctrl_r[3:1], active_r};
                end else if (paddr == `DMASEQ_COUNT_OFS) begin
                    prdata <= {{(32-CW){1'b0}}, count_r};
                end else if (paddr == `DMASEQ_ADDR_OFS) begin
                    prdata <= {{(32-AW){1'b0}}, addr_r};
                end else if (paddr == `DMASEQ_STATUS_OFS) begin
                    prdata <= status_word(st_r,
                        {win_r, sync_r, rq_r, fl_pf_r, fl_err_r, fl_done_r, active_r});
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // sequencer: cleared only at power-up, never by bus reset
    always @(posedge pclk or negedge power_up_memory_disable_n) begin
        if (!power_up_memory_disable_n) begin
            st_r <= S_IDLE;
            rq_r <= 1'b0;
            sync_r <= 1'b0;
            win_r <= 1'b0;
            tmr_r <= 3'h0;
            count_r <= {CW{1'b0}};
            addr_r <= {AW{1'b0}};
            active_r <= 1'b0;
            fl_done_r <= 1'b0;
            fl_err_r <= 1'b0;
            fl_pf_r <= 1'b0;
            halt_ack_n_q <= 1'b1;
            memory_ack_n_q <= 1'b1;
            halt_req_n <= 1'b1;
            mem_start_n <= 1'b1;
            mem_write <= 1'b0;
            mem_byte <= 1'b0;
            mem_addr <= {AW{1'b0}};
            xfer_grant <= 1'b0;
            dma_priority_out_n <= 1'b1;
            end_of_operation_interrupt <= 1'b0;
        end else begin
            halt_ack_n_q <= halt_ack_n;
            memory_ack_n_q <= memory_ack_n;
            xfer_grant <= 1'b0;
            halt_req_n <= ~sync_r;
            dma_priority_out_n <= win_r | dma_priority_in_n;
            if (cnt_we) begin
                count_r <= pwdata[CW-1:0];
            end
            if (adr_we) begin
                addr_r <= pwdata[AW-1:0];
            end
            if (xfer_req && active_r && !pf && st_r != S_TERM) begin
                rq_r <= 1'b1;
            end
            if (go_p) begin
                active_r <= 1'b1;
                fl_done_r <= 1'b0;
                fl_err_r <= 1'b0;
                fl_pf_r <= 1'b0;
                end_of_operation_interrupt <= 1'b0;
                rq_r <= 1'b0;
                st_r <= S_IDLE;
            end else begin
                case (st_r)
                    S_IDLE: begin
                        if (active_r) begin
                            if (xfer_error) begin
                                fl_err_r <= 1'b1;
                                st_r <= S_TERM;
                            end else if (pf) begin
                                fl_pf_r <= 1'b1;
                                st_r <= S_TERM;
                            end else if (count_r == {CW{1'b0}}) begin
                                fl_done_r <= 1'b1;
                                st_r <= S_TERM;
                            end else if (rq_r && halt_ack_n) begin
                                sync_r <= 1'b1;
                                st_r <= S_ACQ;
                            end else if (rq_r && memory_ack_n_trail) begin
                                sync_r <= 1'b1;
                                win_r <= 1'b1;
                                tmr_r <= 3'h0;
                                st_r <= S_AUCT;
                            end
                        end
                    end
                    S_ACQ: begin
                        if (pf) begin
                            fl_pf_r <= 1'b1;
                            st_r <= S_TERM;
                        end else if (halt_ack_n_lead || (!halt_ack_n && memory_ack_n_trail)) begin
                            win_r <= sync_r;
                            tmr_r <= 3'h0;
                            st_r <= S_AUCT;
                        end
                    end
                    S_AUCT: begin
                        if (dma_priority_in_n) begin
                            win_r <= 1'b0;
                            tmr_r <= 3'h0;
                            st_r <= S_ACQ;
                        end else if (ripple_done) begin
                            rq_r <= xfer_req;
                            mem_start_n <= 1'b0;
                            mem_addr <= addr_r;
                            mem_write <= ctrl_r[`DMASEQ_CTRL_DIR];
                            mem_byte <= ctrl_r[`DMASEQ_CTRL_BYTE];
                            st_r <= S_XFER;
                        end else begin
                            tmr_r <= tmr_r + 3'h1;
                        end
                    end
                    S_XFER: begin
                        if (!memory_ack_n) begin
                            mem_start_n <= 1'b1;
                            st_r <= S_POST;
                        end
                    end
                    S_POST: begin
                        if (memory_ack_n) begin
                            count_r <= count_r - {{(CW-1){1'b0}}, 1'b1};
                            addr_r <= addr_r + {{(AW-1){1'b0}}, 1'b1};
                            xfer_grant <= 1'b1;
                            win_r <= 1'b0;
                            tmr_r <= 3'h0;
                            if (xfer_error) begin
                                fl_err_r <= 1'b1;
                                st_r <= S_TERM;
                            end else if (last_xfer) begin
                                fl_done_r <= 1'b1;
                                st_r <= S_TERM;
                            end else if (pf) begin
                                fl_pf_r <= 1'b1;
                                st_r <= S_TERM;
                            end else if (rq_r) begin
                                win_r <= sync_r;
                                st_r <= S_AUCT;
                            end else begin
                                sync_r <= 1'b0;
                                st_r <= S_IDLE;
                            end
                        end
                    end
                    S_TERM: begin
                        sync_r <= 1'b0;
                        win_r <= 1'b0;
                        rq_r <= 1'b0;
                        active_r <= 1'b0;
                        end_of_operation_interrupt <= 1'b1;
                        st_r <= S_IDLE;
                    end
                    default: begin
                        st_r <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // dmaseq_top

// ---- core/dmaseq_consts.vh ----
// Behaviour
// - software loads mode, count, address before starting
// - run after start; each peripheral request starts service
// - service order: bus, auction, transfer
// - request store flag held until transfer stage
// - bus idle: sync flag sets at once, halt request low
// - bus busy: sync flag sets on memory ack
// - daisy chain; priority held while input low
// - wait priority ripple time before transferring
// - auction after halt ack lead, memory ack trail
// - single controller mode skips ripple wait
// - win flag needs sync flag; clocked by ack edges
// - win flag blocks downstream, starts state counter
// - priority input high clears win, request stays pending
// - auction ends after auction interval timeout
// - after transfer decrement count, increment address
// - more transfers re-auction, else terminate
// - sequencer cleared by memory disable, not reset
// - normal at zero count, abnormal on error; flags
// - termination blocks requests, frees bus, raises interrupt
// - power fail finishes cycle, stops, sets flag
// - 16-bit loadable transfer counter
// - 16-bit loadable address counter
`ifndef DMASEQ_CONSTS_VH
`define DMASEQ_CONSTS_VH
`define DMASEQ_CTRL_OFS 8'h00
`define DMASEQ_COUNT_OFS 8'h04
`define DMASEQ_ADDR_OFS 8'h08
`define DMASEQ_STATUS_OFS 8'h0C
`define DMASEQ_CTRL_GO 0
`define DMASEQ_CTRL_DIR 1
`define DMASEQ_CTRL_BYTE 2
`define DMASEQ_CTRL_SINGLE 3
`define DMASEQ_CTRL_RST 4'h0
`define DMASEQ_ST_ACTIVE 0
`define DMASEQ_ST_DONE 1
`define DMASEQ_ST_ERR 2
`define DMASEQ_ST_PF 3
`define DMASEQ_ST_RQ 4
`define DMASEQ_ST_SYNC 5
`define DMASEQ_ST_WIN 6
`define DMASEQ_ST_STATE 8
`define DMASEQ_CLK_NS 50
`define DMASEQ_RIPPLE_NS 200
`define DMASEQ_RIPPLE_CYC ((`DMASEQ_RIPPLE_NS + `DMASEQ_CLK_NS - 1) / `DMASEQ_CLK_NS)
`endif

// ---- test/dmaseq_chk_sva.sv ----
`timescale 1ns/100ps
module dmaseq_chk #(
    parameter AW = 16
) (
    // clock and resets
    input wire pclk,
    input wire presetn,
    input wire power_up_memory_disable_n,
    // apb
    input wire psel,
    input wire penable,
    input wire pready,
    // bus and chain
    input wire power_fail_detect_n,
    input wire xfer_grant,
    input wire halt_ack_n,
    input wire memory_ack_n,
    input wire halt_req_n,
    input wire mem_start_n,
    input wire mem_write,
    input wire [AW-1:0] mem_addr,
    input wire dma_priority_in_n,
    input wire dma_priority_out_n,
    input wire end_of_operation_interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !power_up_memory_disable_n);
    a_apb_ready: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_chain_pass: assert property (dma_priority_in_n |=> dma_priority_out_n)
        else $error("priority passed on while blocked upstream");
    a_prio_held: assert property ($fell(mem_start_n) |-> dma_priority_out_n && $past(!dma_priority_in_n))
        else $error("transfer started without priority");
    a_bus_held: assert property ($fell(mem_start_n) |-> !halt_ack_n && !halt_req_n)
        else $error("transfer started without the bus");
    a_start_hold: assert property (!mem_start_n && memory_ack_n |=> !mem_start_n)
        else $error("memory start dropped before acknowledge");
    a_addr_stable: assert property (!mem_start_n && $past(!mem_start_n) |-> $stable(mem_addr) && $stable(mem_write))
        else $error("address moved during memory cycle");
    a_grant_after: assert property (xfer_grant |-> memory_ack_n ##1 !xfer_grant)
        else $error("grant not a single pulse after acknowledge");
    a_eop_release: assert property ($rose(end_of_operation_interrupt) |-> ##[0:2] halt_req_n)
        else $error("bus not returned at termination");
    a_eop_no_start: assert property (end_of_operation_interrupt |-> mem_start_n)
        else $error("memory cycle after termination");
    a_pf_no_req: assert property ((!power_fail_detect_n)[*3] ##0 halt_req_n |=> halt_req_n)
        else $error("bus requested during power fail");
endmodule // dmaseq_chk

// ---- test/dmaseq_bus_model.sv ----
`timescale 1ns/100ps
module dmaseq_bus_model (
    // clock
    input wire pclk,
    // from the dma controller, plus the testbench latency select
    input wire halt_req_n,
    input wire mem_start_n,
    input wire slow,
    // processor and memory answers
    output reg halt_ack_n,
    output reg memory_ack_n
);
    integer wait_c;
    initial begin
        halt_ack_n = 1'b1;
        memory_ack_n = 1'b1;
        wait_c = 0;
    end
    // processor follows stop request, memory answers start, each after a latency
    always @(posedge pclk) begin
        if (halt_req_n !== halt_ack_n || mem_start_n !== memory_ack_n) begin
            if (wait_c < (slow ? 3 : 0)) begin
                wait_c <= wait_c + 1;
            end else begin
                wait_c <= 0;
                if (halt_req_n !== halt_ack_n) halt_ack_n <= halt_req_n;
                else memory_ack_n <= mem_start_n;
            end
        end
    end
endmodule // dmaseq_bus_model

// ---- test/dmaseq_top_tb.sv ----
`timescale 1ns/100ps
module dmaseq_top_tb;
    localparam AW = 16;
    reg pclk, presetn, psel, penable, pwrite, power_up_memory_disable_n_n, pf_n, xfer_req, xfer_error, prio_n, other_n;
    reg slow, sl;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd, mode;
    reg [AW-1:0] base;
    wire [31:0] prdata;
    wire pready, pslverr, xfer_grant, halt_ack_n, memory_ack_n_n, halt_req_n, mem_start_n, mem_write;
    wire mem_byte, prio_out_n, eop;
    wire [AW-1:0] mem_addr;
    wire memory_ack_n = memory_ack_n_n & other_n;
    integer err_count, tests_run, seed, grants, t, i, n, w;
    reg ms_q;
    dmaseq_top #(.CW(16), .AW(AW), .RIPPLE_CYC(4)) dmaseq_top_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_up_memory_disable_n(power_up_memory_disable_n_n), .power_fail_detect_n(pf_n), .xfer_req(xfer_req),
        .xfer_error(xfer_error), .xfer_grant(xfer_grant), .halt_ack_n(halt_ack_n),
        .memory_ack_n(memory_ack_n), .halt_req_n(halt_req_n), .mem_start_n(mem_start_n),
        .mem_write(mem_write), .mem_byte(mem_byte), .mem_addr(mem_addr),
        .dma_priority_in_n(prio_n), .dma_priority_out_n(prio_out_n),
        .end_of_operation_interrupt(eop));
    dmaseq_bus_model dmaseq_bus_model_i (.pclk(pclk), .halt_req_n(halt_req_n),
        .mem_start_n(mem_start_n), .slow(slow), .halt_ack_n(halt_ack_n), .memory_ack_n(memory_ack_n_n));
    task chk(input [63:0] what, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task apb(input wr, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            for (w = 0; w < 50 && pready !== 1'b1; w = w + 1) @(posedge pclk);
            rd = prdata;
            sl = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task pulse_req;
        begin
            xfer_req <= 1'b1;
            @(posedge pclk);
            xfer_req <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task wait_for(input integer g);
        begin
            for (w = 0; w < 400 && grants < g && eop !== 1'b1; w = w + 1) @(posedge pclk);
        end
    endtask
    task start(input [15:0] cnt, input [31:0] m);
        begin
            grants = 0;
            mode = m;
            apb(1'b1, 8'h04, {16'h0, cnt});
            apb(1'b1, 8'h08, {16'h0, base});
            apb(1'b1, 8'h00, m | 32'h1);
        end
    endtask
    function [31:0] st_exp(input [31:0] f);
        st_exp = 32'h100 | f;
    endfunction
    always @(posedge pclk) begin
        ms_q <= mem_start_n;
        if (ms_q === 1'b1 && mem_start_n === 1'b0) begin
            chk("addr", {16'h0, mem_addr}, (base + grants) & 32'hFFFF);
            chk("mode", {mem_byte, mem_write}, mode[2:1]);
        end
        if (xfer_grant === 1'b1) grants <= grants + 1;
    end
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #3000000;
        err_count = err_count + 1;
        stop_test;
    end
    initial begin
        {presetn, power_up_memory_disable_n_n, psel, penable, pwrite, xfer_req, xfer_error, prio_n, slow} = 9'h0;
        {pf_n, other_n, ms_q} = 3'h7;
        {paddr, pwdata, base, mode} = 88'h0;
        {err_count, tests_run, grants} = 96'h0;
        seed = 32'h202d8558;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        power_up_memory_disable_n_n <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b0, 8'h04 * i, 32'h0);
            chk("reset", rd, (i == 3) ? 32'h100 : 32'h0);
        end
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", {31'h0, sl}, 32'h1);
        $display("test reset done");
        for (t = 0; t < 4; t = t + 1) begin
            n = 1 + ($random(seed) & 3);
            base = (t == 0) ? 16'hFFFE : $random(seed);
            slow = t[0];
            start(n, ($random(seed) & 6) | (t[1] << 3));
            apb(1'b1, 8'h04, 32'hFFFF);
            apb(1'b0, 8'h04, 32'h0);
            chk("locked", rd, n);
            for (i = 1; i <= n; i = i + 1) begin
                pulse_req;
                wait_for(i);
            end
            chk("grants", grants, n);
            apb(1'b0, 8'h04, 32'h0);
            chk("count", rd, 32'h0);
            apb(1'b0, 8'h08, 32'h0);
            chk("addr_end", rd, (base + n) & 32'hFFFF);
            apb(1'b0, 8'h0C, 32'h0);
            chk("status", rd & 32'h3F03, st_exp(32'h2));
            chk("eop", {31'h0, eop}, 32'h1);
            chk("released", {31'h0, halt_req_n}, 32'h1);
            $display("test run %0d done", t);
        end
        start(3, 32'h0);
        xfer_error <= 1'b1;
        wait_for(1);
        xfer_error <= 1'b0;
        apb(1'b0, 8'h0C, 32'h0);
        chk("abnormal", rd & 32'h3F05, st_exp(32'h4));
        $display("test error done");
        start(1, 32'h0);
        prio_n <= 1'b1;
        pulse_req;
        repeat (40) @(posedge pclk);
        chk("aborted", grants, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("pending", rd & 32'h10, 32'h10);
        prio_n <= 1'b0;
        other_n <= 1'b0;
        @(posedge pclk);
        other_n <= 1'b1;
        wait_for(1);
        chk("retried", grants, 32'h1);
        $display("test priority done");
        start(4, 32'h0);
        pf_n <= 1'b0;
        pulse_req;
        wait_for(1);
        repeat (4) @(posedge pclk);
        chk("pf_grant", grants, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("pf_flag", rd & 32'h3F09, st_exp(32'h8));
        pf_n <= 1'b1;
        $display("test power fail done");
        stop_test;
    end
endmodule // dmaseq_top_tb
bind dmaseq_top dmaseq_chk #(.AW(AW)) dmaseq_chk_i (.pclk(pclk), .presetn(presetn),
    .power_up_memory_disable_n(power_up_memory_disable_n), .psel(psel), .penable(penable),
    .pready(pready), .power_fail_detect_n(power_fail_detect_n), .xfer_grant(xfer_grant),
    .halt_ack_n(halt_ack_n), .memory_ack_n(memory_ack_n), .halt_req_n(halt_req_n),
    .mem_start_n(mem_start_n), .mem_write(mem_write), .mem_addr(mem_addr),
    .dma_priority_in_n(dma_priority_in_n), .dma_priority_out_n(dma_priority_out_n),
    .end_of_operation_interrupt(end_of_operation_interrupt));
